/* File: src/ulmc_core.sv */
// Line format, FIFO trigger, modem control and receive status logic of a UART
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ulmc_consts.svh"
module ulmc_core
  import ulmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  input wire logic rxParityIn,
  input wire logic rxTimeout,
  input wire logic [7:0] txData,
  input wire logic txSerialIn,
  input wire logic ctsN,
  input wire logic dsrN,
  input wire logic riN,
  input wire logic cdN,
  output logic txPin,
  output logic txParity,
  output logic [3:0] fmtWordBits,
  output logic [2:0] fmtStopHalves,
  output logic fmtParityEn,
  output logic [15:0] divisorValue,
  output logic [6:0] rxTrigLevel,
  output logic [6:0] txTrigLevel,
  output logic txFifoClear,
  output logic fifoEnabled,
  output logic rxIrq,
  output logic intOut,
  output logic intOutEnN,
  output logic termReadyN,
  output logic reqToSendN,
  output logic gpOutputTwoN,
  output logic loopbackEn,
  output logic irModeEn,
  output logic txHalted,
  output logic baudTick
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ulmc_bus_phase_t phase;
    logic waitReq;
    logic [31:0] rdata;
    logic [7:0] lfc;
    logic [7:0] moc;
    logic [7:0] efeat;
    logic [7:0] spad;
    logic [7:0] thresh;
    logic [7:0] trig;
    logic [7:0] divLo;
    logic [7:0] divHi;
    logic [16:0] flow;
    logic fifoEn;
    logic [1:0] rxSel;
    logic [1:0] txSel;
    logic [63:0][8:0] mem;
    logic [5:0] wp;
    logic [5:0] rp;
    logic [6:0] count;
    logic overrun;
    logic halted;
    logic irq;
    logic intLine;
    logic intEnN;
    logic txLine;
    logic txPar;
    logic txClr;
    logic [3:0] wordBits;
    logic [2:0] stopHalves;
    logic [6:0] rxTrig;
    logic [6:0] txTrig;
  } ulmc_core_state_t;

  ulmc_core_state_t st;
  ulmc_core_state_t next_st;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Parity bit for a character under the current line format
  function automatic logic parityOf(input logic [7:0] data, input logic [1:0] len, input logic [7:0] lfc);
    logic [7:0] mask;
    mask = 8'hff >> (2'h3 - len);
    if (lfc[`ULMC_LFC_FORCE])
      parityOf = ~lfc[`ULMC_LFC_EVEN];
    else
      parityOf = (^(data & mask)) ^ ~lfc[`ULMC_LFC_EVEN];
  endfunction

  // Trigger level: a non-zero nibble from the trigger register wins, else the table
  function automatic logic [6:0] trigOf(input logic [1:0] sel, input logic [3:0] nib, input logic isRx);
    if (nib != 4'h0)
      trigOf = {1'b0, nib, 2'b00};
    else
      case (sel)
        2'h0: trigOf = `ULMC_TRIG_8;
        2'h1: trigOf = `ULMC_TRIG_16;
        2'h2: trigOf = isRx ? `ULMC_TRIG_56 : `ULMC_TRIG_32;
        default: trigOf = isRx ? `ULMC_TRIG_60 : `ULMC_TRIG_56;
      endcase
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [3:0] regIdx;
  logic addrOk;
  logic req;
  logic divSel;
  logic altMap;
  logic [7:0] msrValue;
  logic [7:0] lstValue;
  logic [7:0] wbyte;

  // Word-aligned byte addresses only; anything else reads zero
  assign regIdx = avsAddress[5:2];
  assign addrOk = (avsAddress[1:0] == 2'b00);
  assign req = avsRead | avsWrite;
  assign divSel = st.lfc[`ULMC_LFC_DIVSEL];
  assign altMap = st.efeat[`ULMC_EF_ENH] & st.moc[`ULMC_MOC_GP1];
  assign wbyte = avsWritedata[7:0];

  // Loopback returns the modem outputs as the status inputs
  always_comb
  begin
    msrValue = 8'h00;
    if (st.moc[`ULMC_MOC_LOOP])
      msrValue[7:4] = {st.moc[`ULMC_MOC_GP2], st.moc[`ULMC_MOC_GP1],
                       st.moc[`ULMC_MOC_TREADY], st.moc[`ULMC_MOC_RTS]};
    else
      msrValue[7:4] = ~{cdN, riN, dsrN, ctsN};
  end

  // Line status as software sees it
  always_comb
  begin
    lstValue = 8'h00;
    lstValue[`ULMC_LS_READY] = (st.count != 7'h00);
    lstValue[`ULMC_LS_OVR] = st.overrun;
    lstValue[`ULMC_LS_PERR] = (st.count != 7'h00) & st.mem[st.rp][8];
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic doWrite;
  logic doRead;
  logic pop;
  logic push;
  logic rxFull;
  logic isFlowChar;
  logic overrunSet;
  logic overrunClr;
  logic perr;

  always_comb
  begin
    next_st = st;
    doWrite = 1'b0;
    doRead = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    overrunClr = 1'b0;
    next_st.txClr = 1'b0;

    // Two-step bus answer: read data settles, then the access commits
    case (st.phase)
      ULMC_BUS_IDLE:
      begin
        next_st.waitReq = 1'b1;
        if (req)
        begin
          next_st.phase = ULMC_BUS_ANSWER;
          next_st.waitReq = 1'b0;
          next_st.rdata = 32'h0000_0000;
          if (addrOk && avsRead)
            case (regIdx)
              `ULMC_IDX_DATA: next_st.rdata[7:0] = divSel ? st.divLo : st.mem[st.rp][7:0];
              `ULMC_IDX_DIVHI: next_st.rdata[7:0] = divSel ? st.divHi : 8'h00;
              `ULMC_IDX_FIFO: next_st.rdata[7:0] = {st.fifoEn, st.fifoEn, 6'h00};
              `ULMC_IDX_LFC: next_st.rdata[7:0] = st.lfc;
              `ULMC_IDX_MOC: next_st.rdata[7:0] = st.moc;
              `ULMC_IDX_LST: next_st.rdata[7:0] = lstValue;
              `ULMC_IDX_MSTAT: next_st.rdata[7:0] = altMap ? st.thresh : msrValue;
              `ULMC_IDX_SPAD: next_st.rdata[7:0] = altMap ? st.trig : st.spad;
              `ULMC_IDX_EFEAT: next_st.rdata[7:0] = st.efeat;
              `ULMC_IDX_FLOW: next_st.rdata[16:0] = st.flow;
              default: next_st.rdata = 32'h0000_0000;
            endcase
        end
      end
      ULMC_BUS_ANSWER:
      begin
        next_st.phase = ULMC_BUS_IDLE;
        next_st.waitReq = 1'b1;
        doWrite = avsWrite & addrOk & avsByteenable[0];
        doRead = avsRead & addrOk;
      end
      default:
      begin
        next_st.phase = ULMC_BUS_IDLE;
        next_st.waitReq = 1'b1;
      end
    endcase

    // Register writes
    if (doWrite)
      case (regIdx)
        `ULMC_IDX_DATA: if (divSel) next_st.divLo = wbyte;
        `ULMC_IDX_DIVHI: if (divSel) next_st.divHi = wbyte;
        `ULMC_IDX_FIFO:
        begin
          next_st.fifoEn = wbyte[`ULMC_FC_EN];
          if (wbyte[`ULMC_FC_EN])
          begin
            next_st.rxSel = wbyte[7:6];
            next_st.txSel = wbyte[5:4];
            next_st.txClr = wbyte[`ULMC_FC_TXRST];
          end
        end
        `ULMC_IDX_LFC: next_st.lfc = wbyte;
        `ULMC_IDX_MOC:
        begin
          next_st.moc[4:0] = wbyte[4:0];
          if (st.efeat[`ULMC_EF_ENH])
            next_st.moc[7:5] = wbyte[7:5];
        end
        `ULMC_IDX_MSTAT: if (altMap) next_st.thresh = wbyte;
        `ULMC_IDX_SPAD:
        begin
          if (altMap)
            next_st.trig = wbyte;
          else
            next_st.spad = wbyte;
        end
        `ULMC_IDX_EFEAT: next_st.efeat = wbyte;
        `ULMC_IDX_FLOW:
        begin
          next_st.flow[7:0] = wbyte;
          if (avsByteenable[1])
            next_st.flow[15:8] = avsWritedata[15:8];
          if (avsByteenable[2])
            next_st.flow[16] = avsWritedata[16];
        end
        default: next_st.lfc = st.lfc;
      endcase

    // Read side effects
    if (doRead && regIdx == `ULMC_IDX_DATA && !divSel && st.count != 7'h00)
      pop = 1'b1;
    if (doRead && regIdx == `ULMC_IDX_LST)
      overrunClr = 1'b1;

    // Software flow characters and Xon-any
    isFlowChar = st.flow[`ULMC_FLOW_SW] &&
                 (rxChar == st.flow[7:0] || rxChar == st.flow[15:8]);
    if (rxCharValid)
    begin
      if (isFlowChar)
        next_st.halted = (rxChar == st.flow[15:8]);
      else if (st.moc[`ULMC_MOC_XANY])
        next_st.halted = 1'b0;
    end

    // Receive FIFO: a full FIFO drops the character and keeps its contents
    rxFull = (st.count == (st.fifoEn ? `ULMC_FIFO_DEPTH : 7'h01));
    perr = st.lfc[`ULMC_LFC_PEN] & (rxParityIn != parityOf(rxChar, st.lfc[1:0], st.lfc));
    overrunSet = rxCharValid & ~isFlowChar & rxFull & ~pop;
    push = rxCharValid & ~isFlowChar & (~rxFull | pop);
    if (push)
    begin
      next_st.mem[st.wp] = {perr, rxChar};
      next_st.wp = st.wp + 6'h01;
    end
    if (pop)
      next_st.rp = st.rp + 6'h01;
    next_st.count = st.count + {6'h00, push} - {6'h00, pop};
    // A new overrun beats the clearing read
    next_st.overrun = overrunSet | (st.overrun & ~overrunClr);

    // Receive FIFO reset clears pointers and count only; shift register is elsewhere
    if (doWrite && regIdx == `ULMC_IDX_FIFO && wbyte[`ULMC_FC_EN] && wbyte[`ULMC_FC_RXRST])
    begin
      next_st.wp = 6'h00;
      next_st.rp = 6'h00;
      next_st.count = 7'h00;
    end

    // Decoded format and trigger outputs follow the stored registers
    next_st.wordBits = {2'b00, next_st.lfc[1:0]} + 4'h5;
    if (!next_st.lfc[`ULMC_LFC_STOP])
      next_st.stopHalves = 3'h2;
    else
      next_st.stopHalves = (next_st.lfc[1:0] == 2'b00) ? 3'h3 : 3'h4;
    next_st.rxTrig = trigOf(next_st.rxSel, next_st.trig[7:4], 1'b1);
    next_st.txTrig = trigOf(next_st.txSel, next_st.trig[3:0], 1'b0);
    next_st.txPar = parityOf(txData, next_st.lfc[1:0], next_st.lfc);

    // Interrupt line and its enable
    next_st.irq = (next_st.count > next_st.rxTrig) | rxTimeout;
    next_st.intLine = next_st.irq;
    next_st.intEnN = ~next_st.moc[`ULMC_MOC_GP2];

    // Break overrides all; loopback keeps the pin idle at mark
    if (next_st.lfc[`ULMC_LFC_BREAK])
      next_st.txLine = 1'b0;
    else if (next_st.moc[`ULMC_MOC_LOOP])
      next_st.txLine = 1'b1;
    else
      next_st.txLine = txSerialIn;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.phase <= ULMC_BUS_IDLE;
      st.waitReq <= 1'b1;
      st.lfc <= `ULMC_LFC_RST;
      st.moc <= `ULMC_MOC_RST;
      st.spad <= `ULMC_SPAD_RST;
      st.flow <= `ULMC_FLOW_RST;
      st.wordBits <= 4'h6;
      st.stopHalves <= 3'h4;
      st.rxTrig <= `ULMC_TRIG_8;
      st.txTrig <= `ULMC_TRIG_8;
      st.intEnN <= 1'b1;
      st.txLine <= 1'b1;
    end
    else if (clkEn)
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Baud prescaler
  // ---------------------------------------------------------------
  ulmc_prescaler presc (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .divideByFour(st.moc[`ULMC_MOC_PRESC]),
    .baudTick(baudTick)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avsReaddata = st.rdata;
  assign avsWaitrequest = st.waitReq;
  assign txPin = st.txLine;
  assign txParity = st.txPar;
  assign fmtWordBits = st.wordBits;
  assign fmtStopHalves = st.stopHalves;
  assign fmtParityEn = st.lfc[`ULMC_LFC_PEN];
  assign divisorValue = {st.divHi, st.divLo};
  assign rxTrigLevel = st.rxTrig;
  assign txTrigLevel = st.txTrig;
  assign txFifoClear = st.txClr;
  assign fifoEnabled = st.fifoEn;
  assign rxIrq = st.irq;
  assign intOut = st.intLine;
  assign intOutEnN = st.intEnN;
  assign termReadyN = ~st.moc[`ULMC_MOC_TREADY];
  assign reqToSendN = ~st.moc[`ULMC_MOC_RTS];
  assign gpOutputTwoN = ~st.moc[`ULMC_MOC_GP2];
  assign loopbackEn = st.moc[`ULMC_MOC_LOOP];
  assign irModeEn = st.moc[`ULMC_MOC_IR];
  assign txHalted = st.halted;
endmodule
`default_nettype wire

/* File: src/ulmc_consts.svh */
// Register indices, field positions, reset values and sizes of the line/modem control block
`ifndef ULMC_CONSTS_SVH
`define ULMC_CONSTS_SVH
// Register indices; byte address is four times the index
`define ULMC_IDX_DATA 4'h0
`define ULMC_IDX_DIVHI 4'h1
`define ULMC_IDX_FIFO 4'h2
`define ULMC_IDX_LFC 4'h3
`define ULMC_IDX_MOC 4'h4
`define ULMC_IDX_LST 4'h5
`define ULMC_IDX_MSTAT 4'h6
`define ULMC_IDX_SPAD 4'h7
`define ULMC_IDX_EFEAT 4'h8
`define ULMC_IDX_FLOW 4'h9
// Line format control fields
`define ULMC_LFC_STOP 2
`define ULMC_LFC_PEN 3
`define ULMC_LFC_EVEN 4
`define ULMC_LFC_FORCE 5
`define ULMC_LFC_BREAK 6
`define ULMC_LFC_DIVSEL 7
// Modem output control fields
`define ULMC_MOC_TREADY 0
`define ULMC_MOC_RTS 1
`define ULMC_MOC_GP1 2
`define ULMC_MOC_GP2 3
`define ULMC_MOC_LOOP 4
`define ULMC_MOC_XANY 5
`define ULMC_MOC_IR 6
`define ULMC_MOC_PRESC 7
// FIFO control fields
`define ULMC_FC_EN 0
`define ULMC_FC_RXRST 1
`define ULMC_FC_TXRST 2
// Enhanced feature and flow register fields
`define ULMC_EF_ENH 4
`define ULMC_FLOW_SW 16
// Line status fields
`define ULMC_LS_READY 0
`define ULMC_LS_OVR 1
`define ULMC_LS_PERR 2
// Reset values
`define ULMC_LFC_RST 8'h05
`define ULMC_MOC_RST 8'h00
`define ULMC_SPAD_RST 8'hff
`define ULMC_FLOW_RST 17'h01311
// Sizes and trigger levels
`define ULMC_FIFO_DEPTH 7'h40
`define ULMC_TRIG_8 7'h08
`define ULMC_TRIG_16 7'h10
`define ULMC_TRIG_32 7'h20
`define ULMC_TRIG_56 7'h38
`define ULMC_TRIG_60 7'h3c
`define ULMC_PRESC_LAST 2'h3
`endif

/* File: src/ulmc_pkg.sv */
// Types shared by the line/modem control block
package ulmc_pkg;
  typedef enum logic {ULMC_BUS_IDLE, ULMC_BUS_ANSWER} ulmc_bus_phase_t;
  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } ulmc_presc_state_t;
endpackage

/* File: src/ulmc_prescaler.sv */
// Baud clock prescaler: passes every input clock or one in four
`timescale 1ns/1ps
`default_nettype none
`include "ulmc_consts.svh"
module ulmc_prescaler
  import ulmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic divideByFour,
  output logic baudTick
);
  ulmc_presc_state_t st;
  ulmc_presc_state_t next_st;

  // Divide by one gives a tick every cycle, divide by four every fourth
  always_comb
  begin
    next_st = st;
    if (divideByFour)
    begin
      next_st.cnt = (st.cnt == `ULMC_PRESC_LAST) ? 2'h0 : st.cnt + 2'h1;
      next_st.tick = (st.cnt == `ULMC_PRESC_LAST);
    end
    else
    begin
      next_st.cnt = 2'h0;
      next_st.tick = 1'b1;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else if (clkEn)
      st <= next_st;
  end

  assign baudTick = st.tick;
endmodule
`default_nettype wire

/* File: tb/ulmc_asserts.sv */
// Port-level checks of the line/modem control block
`timescale 1ns/1ps
`default_nettype none
module ulmc_asserts
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic avsWaitrequest,
  input wire logic rxTimeout,
  input wire logic [7:0] txData,
  input wire logic txSerialIn,
  input wire logic txPin,
  input wire logic txParity,
  input wire logic [3:0] fmtWordBits,
  input wire logic [2:0] fmtStopHalves,
  input wire logic fmtParityEn,
  input wire logic [6:0] rxTrigLevel,
  input wire logic rxIrq,
  input wire logic intOut,
  input wire logic intOutEnN,
  input wire logic termReadyN,
  input wire logic reqToSendN,
  input wire logic gpOutputTwoN,
  input wire logic loopbackEn
);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic [7:0] lfcSh;
  logic [7:0] mocSh;
  logic [1:0] rxSel;
  logic [1:0] quiet;
  logic wrDone;
  assign wrDone = avsWrite && !avsWaitrequest && avsByteenable[0];
  // Outputs are trusted only four cycles after a write, so register lag never fires a check
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lfcSh <= 8'h05;
      mocSh <= 8'h00;
      rxSel <= 2'h0;
      quiet <= 2'h3;
    end
    else
    begin
      if (wrDone && avsAddress == 6'h0c)
        lfcSh <= avsWritedata[7:0];
      if (wrDone && avsAddress == 6'h10)
        mocSh <= avsWritedata[7:0];
      if (wrDone && avsAddress == 6'h08 && avsWritedata[0])
        rxSel <= avsWritedata[7:6];
      quiet <= wrDone ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_ask;
    (avsRead || avsWrite) && avsWaitrequest && clkEn;
  endsequence
  sequence s_grant;
    !avsWaitrequest ##1 avsWaitrequest;
  endsequence
  property p_bus; s_ask |=> s_grant; endproperty
  property p_idle; !(avsRead || avsWrite) |=> avsWaitrequest; endproperty
  property p_format; quiet == 2'h3 |-> fmtWordBits == 4'h5 + {2'h0, lfcSh[1:0]} && fmtParityEn == lfcSh[3]; endproperty
  property p_stop; quiet == 2'h3 |-> fmtStopHalves == (!lfcSh[2] ? 3'h2 : (lfcSh[1:0] == 2'h0 ? 3'h3 : 3'h4)); endproperty
  // Parity covers only the bits of the programmed word length
  property p_parity; quiet == 2'h3 && !wrDone && lfcSh[3] |=> txParity == (lfcSh[5] ? !lfcSh[4] :
    lfcSh[4] ^ ~^($past(txData) & (8'hff >> (2'h3 - lfcSh[1:0])))); endproperty
  property p_break; quiet == 2'h3 && lfcSh[6] |-> !txPin; endproperty
  property p_pass; quiet == 2'h3 && !wrDone && !lfcSh[6] && !mocSh[4] |=> txPin == $past(txSerialIn); endproperty
  property p_modem; quiet == 2'h3 |-> {termReadyN, reqToSendN, gpOutputTwoN, intOutEnN, loopbackEn} ==
    {~mocSh[0], ~mocSh[1], ~mocSh[3], ~mocSh[3], mocSh[4]}; endproperty
  property p_trig; quiet == 2'h3 |-> rxTrigLevel == (rxSel[1] ? (rxSel[0] ? 7'h3c : 7'h38) : (rxSel[0] ? 7'h10 : 7'h08)); endproperty
  property p_irq; rxTimeout && clkEn |=> rxIrq && intOut; endproperty
  a_bus: assert property (p_bus) else $error("waitrequest not low for exactly one cycle");
  a_idle: assert property (p_idle) else $error("waitrequest low without request");
  a_format: assert property (p_format) else $error("word length or parity enable wrong");
  a_stop: assert property (p_stop) else $error("stop length wrong");
  a_parity: assert property (p_parity) else $error("transmit parity wrong");
  a_break: assert property (p_break) else $error("break not holding output low");
  a_pass: assert property (p_pass) else $error("serial output not passed through");
  a_modem: assert property (p_modem) else $error("modem outputs wrong");
  a_trig: assert property (p_trig) else $error("receive trigger wrong");
  a_irq: assert property (p_irq) else $error("timeout gave no receive interrupt");
endmodule
bind ulmc_core ulmc_asserts i_chk (.sys_clk, .rstn, .clkEn, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
  .avsByteenable, .avsWaitrequest, .rxTimeout, .txData, .txSerialIn, .txPin, .txParity, .fmtWordBits,
  .fmtStopHalves, .fmtParityEn, .rxTrigLevel, .rxIrq, .intOut, .intOutEnN, .termReadyN, .reqToSendN,
  .gpOutputTwoN, .loopbackEn);
`default_nettype wire

/* File: tb/ulmc_serial_peer.sv */
// Remote serial device feeding the receive stream and modem inputs
`timescale 1ns/1ps
`default_nettype none
module ulmc_serial_peer
(
  input wire logic sys_clk,
  output logic rxCharValid,
  output logic [7:0] rxChar,
  output logic rxParityIn,
  output logic rxTimeout,
  output logic ctsN,
  output logic dsrN,
  output logic riN,
  output logic cdN
);
  // ----------------------------------------
  // Line drivers
  // ----------------------------------------
  // Modem inputs idle at their inactive high level
  assign ctsN = 1'b1;
  assign dsrN = 1'b1;
  assign riN = 1'b1;
  assign cdN = 1'b1;
  initial
  begin
    rxCharValid = 1'b0;
    rxChar = 8'h5a;
    rxParityIn = 1'b0;
    rxTimeout = 1'b0;
  end
  // Back-to-back characters; the data bus is inverted afterwards so stale bytes never look valid
  task automatic send(input logic [7:0] c, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      rxCharValid <= 1'b1;
      rxChar <= c + 8'(i);
      rxParityIn <= ~^(c + 8'(i));
    end
    @(posedge sys_clk);
    rxCharValid <= 1'b0;
    rxChar <= ~rxChar;
  endtask
  // One-cycle receive timeout
  task automatic signalTimeout();
    @(posedge sys_clk);
    rxTimeout <= 1'b1;
    @(posedge sys_clk);
    rxTimeout <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/uart_line_modem_control_test.sv */
// Self-checking bench of the line/modem control block
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_control_test;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic sys_clk = 1'b0, rstn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, txSerialIn = 1'b1;
  logic [5:0] avsAddress = 6'h00;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, rd;
  logic [7:0] txData = 8'h00, rxChar, dv;
  logic avsWaitrequest, rxCharValid, rxParityIn, rxTimeout, ctsN, dsrN, riN, cdN, txPin, txParity, fmtParityEn;
  logic [3:0] fmtWordBits;
  logic [2:0] fmtStopHalves;
  logic [15:0] divisorValue;
  logic [6:0] rxTrigLevel, txTrigLevel;
  logic rxIrq, intOut, intOutEnN, termReadyN, reqToSendN, gpOutputTwoN, loopbackEn, irModeEn, txHalted, baudTick;
  logic txClr, fifoOn;
  logic [6:0] rxTab [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
  logic [6:0] txTab [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  int failures = 0, n_tests = 0, cnt;
  always #5 sys_clk = ~sys_clk;
  // Stand-in for the transmit shifter: a bit that changes every cycle
  always @(posedge sys_clk) txSerialIn <= ~txSerialIn;
  ulmc_core i_dut (.sys_clk, .rstn, .clkEn(1'b1), .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsByteenable(4'hf), .avsReaddata, .avsWaitrequest, .rxCharValid, .rxChar, .rxParityIn, .rxTimeout,
    .txData, .txSerialIn, .ctsN, .dsrN, .riN, .cdN, .txPin, .txParity, .fmtWordBits, .fmtStopHalves,
    .fmtParityEn, .divisorValue, .rxTrigLevel, .txTrigLevel, .txFifoClear(txClr), .fifoEnabled(fifoOn), .rxIrq,
    .intOut, .intOutEnN, .termReadyN, .reqToSendN, .gpOutputTwoN, .loopbackEn, .irModeEn, .txHalted, .baudTick);
  ulmc_serial_peer i_peer (.sys_clk, .rxCharValid, .rxChar, .rxParityIn, .rxTimeout, .ctsN, .dsrN, .riN, .cdN);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low; only the watchdog ends the wait
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    avsAddress <= {idx, 2'b00};
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= wd;
    @(posedge sys_clk);
    while (avsWaitrequest !== 1'b0)
      @(posedge sys_clk);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp, input string what);
    bus(1'b0, idx, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic complete_run();
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    rdc(4'h3, 32'h05, "format reset");
    rdc(4'h4, 32'h00, "modem reset");
    rdc(4'h5, 32'h00, "status reset");
    check("pins reset", 32'({termReadyN, reqToSendN, gpOutputTwoN, intOutEnN, irModeEn}), 32'h1e);
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h3, 32'(i));
      idle(2);
      check("word bits", 32'(fmtWordBits), 32'(5 + i % 4));
      check("stop halves", 32'(fmtStopHalves), (i < 4) ? 32'd2 : (i == 4) ? 32'd3 : 32'd4);
    end
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h3, 32'(8'h0b + 16 * m));
      for (int d = 0; d < 256; d += 37)
      begin
        dv = 8'(d);
        @(posedge sys_clk);
        txData <= dv;
        idle(1);
        check("tx parity", 32'(txParity), 32'((m >= 2) ? (m == 2) : (m == 1) ? ^dv : ~^dv));
      end
      check("parity on", 32'(fmtParityEn), 32'h1);
    end
    wr(4'h3, 32'h43);
    idle(3);
    check("break", 32'(txPin), 32'h0);
    wr(4'h3, 32'h83);
    wr(4'h0, 32'h34);
    wr(4'h1, 32'h12);
    wr(4'h3, 32'h03);
    check("divisor", 32'(divisorValue), 32'h1234);
    wr(4'h4, 32'h0b);
    idle(2);
    check("modem on", 32'({termReadyN, reqToSendN, gpOutputTwoN, intOutEnN}), 32'h0);
    wr(4'h4, 32'he0);
    rdc(4'h4, 32'h00, "gated bits");
    wr(4'h8, 32'h10);
    wr(4'h4, 32'h40);
    idle(2);
    check("ir mode", 32'(irModeEn), 32'h1);
    for (int p = 0; p < 2; p++)
    begin
      wr(4'h4, p ? 32'h00 : 32'h80);
      idle(2);
      cnt = 0;
      repeat (8) @(posedge sys_clk) cnt += baudTick;
      check("baud ticks", 32'(cnt), p ? 32'd8 : 32'd2);
    end
    wr(4'h4, 32'h04);
    wr(4'h7, 32'h00);
    wr(4'h4, 32'h00);
    rdc(4'h7, 32'hff, "scratch kept");
    wr(4'h9, 32'h11311);
    i_peer.send(8'h13, 1);
    idle(3);
    check("halted", 32'(txHalted), 32'h1);
    rdc(4'h5, 32'h00, "flow char dropped");
    wr(4'h4, 32'h20);
    i_peer.send(8'h41, 1);
    idle(3);
    check("resumed", 32'(txHalted), 32'h0);
    rdc(4'h0, 32'h41, "resume char");
    wr(4'h3, 32'h1b);
    i_peer.send(8'h01, 1);
    idle(2);
    rdc(4'h5, 32'h05, "parity error");
    rdc(4'h0, 32'h01, "parity char");
    wr(4'h3, 32'h03);
    wr(4'h9, 32'h01311);
    wr(4'h8, 32'h00);
    wr(4'h4, 32'h15);
    idle(2);
    check("loopback", 32'({loopbackEn, txPin}), 32'h3);
    rdc(4'h6, 32'h60, "loop status");
    wr(4'h4, 32'h00);
    wr(4'h2, 32'hc4);
    @(negedge sys_clk);
    check("no clear", 32'({txClr, fifoOn}), 32'h0);
    idle(2);
    check("no enable", 32'(rxTrigLevel), 32'h08);
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h2, 32'(k * 80 + 1));
      idle(2);
      check("rx trigger", 32'(rxTrigLevel), 32'(rxTab[k]));
      check("tx trigger", 32'(txTrigLevel), 32'(txTab[k]));
    end
    wr(4'h2, 32'h05);
    @(negedge sys_clk);
    check("tx clear", 32'({txClr, fifoOn}), 32'h3);
    i_peer.signalTimeout();
    @(negedge sys_clk);
    check("timeout irq", 32'(rxIrq), 32'h1);
    i_peer.send(8'h00, 8);
    idle(3);
    check("at trigger", 32'(rxIrq), 32'h0);
    i_peer.send(8'h08, 56);
    i_peer.send(8'haa, 1);
    idle(3);
    check("over trigger", 32'(rxIrq), 32'h1);
    rdc(4'h5, 32'h03, "overrun set");
    rdc(4'h5, 32'h01, "overrun cleared");
    rdc(4'h0, 32'h00, "head kept");
    complete_run();
  end
  // Whole run is a few hundred cycles; this margin catches a hung handshake
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
